// File: core/tcisp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// small flop fifo with registered full and empty flags
module tcisp_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH]; // storage
   logic [AW-1:0] wr_ptr_q; // next free slot
   logic [AW-1:0] rd_ptr_q; // oldest entry
   logic [AW:0] count_q; // fill level
   logic full_q; // no room left
   logic avail_q; // something stored, drives out_valid directly
   logic push; // accepted write
   logic pop; // accepted read
   logic [AW:0] count_d; // next fill level

   assign push = in_valid & ~full_q;
   assign pop = out_ready & avail_q;
   assign in_ready = ~full_q;
   assign out_valid = avail_q;
   assign out_data = mem_q[rd_ptr_q];

   // fill level update
   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   // pointers and flags
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         full_q <= 1'b0;
         avail_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_d;
         full_q <= (count_d == (AW + 1)'(DEPTH));
         avail_q <= (count_d != '0);
      end
   end

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

endmodule

`default_nettype wire

// File: core/tcisp_pkg.sv
// shared constants and types of the touch controller serial slave port
package tcisp_pkg;

   // write address of each selectable pair, read address is this plus one
   localparam logic [7:0] ADDR_PAIR0_WR = 8'hba;
   localparam logic [7:0] ADDR_PAIR1_WR = 8'h28;

   // host clock rate ceiling, for the bench only
   localparam int BUS_RATE_KBPS = 400;

   // rising clock edges in one byte: eight data bits, then the ack slot
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;

   // cycles after reset release in which the strap level is copied;
   // the filtered strap only settles on the fourth edge, so copy past it
   localparam logic [2:0] STRAP_WAIT = 3'h7;

   // reset level of the pin synchroniser: {strap, scl, sda}
   localparam logic [2:0] PIN_RST = 3'h3;

   // reset value of the register pointer
   localparam logic [15:0] PTR_RST = 16'h0000;

   // write buffer depth in words
   localparam int WR_FIFO_DEPTH = 8;

   // one buffered register write
   typedef struct packed {
      logic [15:0] addr; // register address
      logic [7:0] data; // byte written
   } tcisp_wr_s;

   // byte phases of a transaction
   typedef enum logic [2:0] {
      ST_IDLE, // waiting for a start
      ST_ADDR, // receiving the slave address
      ST_REG_HI, // receiving pointer high byte
      ST_REG_LO, // receiving pointer low byte
      ST_WDATA, // receiving write data
      ST_RDATA // sending read data
   } tcisp_state_e;

endpackage

// File: core/tcisp_slave.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - slave only, never starts a transfer
// - strap picks one of two address pairs
// - detect start, then receive address
// - matching address acked low in ninth clock
// - mismatch: stay idle, SDA released
// - nine clocks per byte, receiver acks
// - sample on SCL high, change on low
// - stop returns port to waiting
// - pointer steps by one per written byte
// - writes continue until stop or a refused byte
// - send bytes while host keeps acking
// - host nack then stop ends reading
module tcisp_slave (
   input wire logic clk,
   input wire logic nrst,
   // serial bus, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // power-on address selection level
   input wire logic addr_alt_strap,
   output logic addr_alt,
   // buffered register writes
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [15:0] wr_addr,
   output logic [7:0] wr_data,
   // register reads
   output logic rd_req,
   output logic [15:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);

   // filtered pin levels
   logic [2:0] pins_f; // {strap, scl, sda}
   logic scl_f; // clean clock level
   logic sda_f; // clean data level
   logic strap_f; // clean strap level
   logic scl_prev_q; // clock level one cycle ago
   logic sda_prev_q; // data level one cycle ago

   // bus events
   logic scl_rise; // clock went high
   logic scl_fall; // clock went low
   logic bus_start; // start or repeated start
   logic bus_stop; // stop

   // strap capture
   logic [2:0] strap_cnt_q; // wait after reset
   logic addr_alt_q; // selected pair

   // byte engine
   tcisp_pkg::tcisp_state_e state_q; // byte phase
   logic [3:0] bit_cnt_q; // rising edges in this byte
   logic [7:0] shift_q; // received bits
   logic [7:0] tx_q; // bits still to send
   logic dir_rd_q; // read direction requested
   logic ack_q; // we acked this byte
   logic mack_q; // host acked our byte
   logic sda_oe_q; // pulling data low
   logic sda_o_q; // driven level, always low

   // pointer and read path
   logic [15:0] ptr_q; // register pointer
   logic rd_req_q; // read request pulse
   logic [15:0] rd_addr_q; // read request address
   logic [7:0] rd_buf_q; // fetched byte

   // decoded conditions
   logic rx_phase; // a byte comes from the host
   logic [7:0] own_wr; // selected write address
   logic addr_hit; // address byte is ours
   logic ack_ok; // byte may be acked
   logic ev_ack; // fall that opens the ack slot
   logic ev_end; // fall that closes the ninth clock
   logic ev_load; // next read byte goes out
   logic push; // write data goes to the buffer
   logic fifo_in_ready; // buffer has room
   tcisp_pkg::tcisp_wr_s wr_word; // word pushed
   tcisp_pkg::tcisp_wr_s wr_head; // word at buffer head

   // pin synchroniser for clock, data and strap
   tcisp_sync #(
      .W(3),
      .RST(tcisp_pkg::PIN_RST)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin({addr_alt_strap, scl_i, sda_i}),
      .level_q(pins_f)
   );

   assign strap_f = pins_f[2];
   assign scl_f = pins_f[1];
   assign sda_f = pins_f[0];

   // previous levels for edge finding
   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   // edges; data is only looked at while the clock is high
   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign bus_stop = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   // strap caught once the synchroniser has filled after release
   always_ff @(posedge clk) begin
      if (!nrst) begin
         strap_cnt_q <= '0;
         addr_alt_q <= 1'b0;
      end else if (strap_cnt_q != tcisp_pkg::STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 1'b1;
         addr_alt_q <= strap_f;
      end
   end

   // address pair in use
   assign own_wr = addr_alt_q ? tcisp_pkg::ADDR_PAIR1_WR
                              : tcisp_pkg::ADDR_PAIR0_WR;
   assign addr_hit = (shift_q[7:1] == own_wr[7:1]);

   // phases in which the host is the sender
   assign rx_phase = (state_q == tcisp_pkg::ST_ADDR) ||
                     (state_q == tcisp_pkg::ST_REG_HI) ||
                     (state_q == tcisp_pkg::ST_REG_LO) ||
                     (state_q == tcisp_pkg::ST_WDATA);

   // ack decision per phase
   always_comb begin
      case (state_q)
         tcisp_pkg::ST_ADDR: ack_ok = addr_hit;
         tcisp_pkg::ST_WDATA: ack_ok = fifo_in_ready;
         tcisp_pkg::ST_REG_HI: ack_ok = 1'b1;
         tcisp_pkg::ST_REG_LO: ack_ok = 1'b1;
         default: ack_ok = 1'b0;
      endcase
   end

   // byte boundaries
   assign ev_ack = scl_fall & rx_phase & (bit_cnt_q == tcisp_pkg::BYTE_BITS);
   assign ev_end = scl_fall & (state_q != tcisp_pkg::ST_IDLE) &
                   (bit_cnt_q == tcisp_pkg::ACK_SLOT);
   assign ev_load = ev_end & (((state_q == tcisp_pkg::ST_ADDR) & dir_rd_q & ack_q) |
                              ((state_q == tcisp_pkg::ST_RDATA) & mack_q));
   assign push = ev_ack & (state_q == tcisp_pkg::ST_WDATA) & fifo_in_ready;

   // phase machine; nothing moves until the host starts
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= tcisp_pkg::ST_IDLE;
      end else if (bus_start) begin
         state_q <= tcisp_pkg::ST_ADDR;
      end else if (bus_stop) begin
         state_q <= tcisp_pkg::ST_IDLE;
      end else if (ev_ack && (state_q == tcisp_pkg::ST_ADDR) && !addr_hit) begin
         state_q <= tcisp_pkg::ST_IDLE;
      end else if (ev_end) begin
         case (state_q)
            tcisp_pkg::ST_ADDR: begin
               // direction bit picks read or pointer phase
               state_q <= dir_rd_q ? tcisp_pkg::ST_RDATA : tcisp_pkg::ST_REG_HI;
            end
            tcisp_pkg::ST_REG_HI: begin
               state_q <= tcisp_pkg::ST_REG_LO;
            end
            tcisp_pkg::ST_REG_LO: begin
               state_q <= tcisp_pkg::ST_WDATA;
            end
            tcisp_pkg::ST_WDATA: begin
               // a refused byte ends our part of the write
               state_q <= ack_q ? tcisp_pkg::ST_WDATA : tcisp_pkg::ST_IDLE;
            end
            tcisp_pkg::ST_RDATA: begin
               // host nack: wait quietly for the stop
               state_q <= mack_q ? tcisp_pkg::ST_RDATA : tcisp_pkg::ST_IDLE;
            end
            default: begin
               state_q <= tcisp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // bit counter counts rising clock edges of one byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bit_cnt_q <= '0;
      end else if (bus_start || bus_stop) begin
         bit_cnt_q <= '0;
      end else if (ev_end) begin
         bit_cnt_q <= '0;
      end else if (scl_rise && (bit_cnt_q != tcisp_pkg::ACK_SLOT)) begin
         bit_cnt_q <= bit_cnt_q + 1'b1;
      end
   end

   // receive shifter, msb first, sampled on rising clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shift_q <= '0;
      end else if (scl_rise && rx_phase && (bit_cnt_q < tcisp_pkg::BYTE_BITS)) begin
         shift_q <= {shift_q[6:0], sda_f};
      end
   end

   // direction, own ack and host ack flags
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dir_rd_q <= 1'b0;
         ack_q <= 1'b0;
         mack_q <= 1'b0;
      end else begin
         if (ev_ack) begin
            ack_q <= ack_ok;
            if (state_q == tcisp_pkg::ST_ADDR) begin
               dir_rd_q <= shift_q[0];
            end
         end
         // host answer sampled on the ninth rising edge
         if (scl_rise && (state_q == tcisp_pkg::ST_RDATA) &&
             (bit_cnt_q == tcisp_pkg::BYTE_BITS)) begin
            mack_q <= ~sda_f;
         end
      end
   end

   // data line driver, changes only just after a falling clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sda_oe_q <= 1'b0;
         sda_o_q <= 1'b0;
         tx_q <= '0;
      end else if (bus_start || bus_stop) begin
         sda_oe_q <= 1'b0;
      end else if (ev_ack) begin
         sda_oe_q <= ack_ok;
      end else if (ev_load) begin
         sda_oe_q <= ~rd_buf_q[7];
         tx_q <= {rd_buf_q[6:0], 1'b0};
      end else if (ev_end) begin
         sda_oe_q <= 1'b0;
      end else if (scl_fall && (state_q == tcisp_pkg::ST_RDATA)) begin
         if (bit_cnt_q == tcisp_pkg::BYTE_BITS) begin
            sda_oe_q <= 1'b0;
         end else if (bit_cnt_q != 4'h0) begin
            sda_oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // register pointer: loaded by the host, stepped per byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ptr_q <= tcisp_pkg::PTR_RST;
      end else if (ev_ack && (state_q == tcisp_pkg::ST_REG_HI)) begin
         ptr_q[15:8] <= shift_q;
      end else if (ev_ack && (state_q == tcisp_pkg::ST_REG_LO)) begin
         ptr_q[7:0] <= shift_q;
      end else if (push) begin
         ptr_q <= ptr_q + 16'h0001;
      end else if (ev_load) begin
         ptr_q <= ptr_q + 16'h0001;
      end
   end

   // read requests: first byte on address match, then one ahead
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_req_q <= 1'b0;
         rd_addr_q <= '0;
      end else if (ev_ack && (state_q == tcisp_pkg::ST_ADDR) && addr_hit && shift_q[0]) begin
         rd_req_q <= 1'b1;
         rd_addr_q <= ptr_q;
      end else if (ev_load) begin
         rd_req_q <= 1'b1;
         rd_addr_q <= ptr_q + 16'h0001;
      end else begin
         rd_req_q <= 1'b0;
      end
   end

   // fetched byte held until it goes out
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_buf_q <= '0;
      end else if (rd_valid) begin
         rd_buf_q <= rd_data;
      end
   end

   // write word and buffer toward the register space
   assign wr_word.addr = ptr_q;
   assign wr_word.data = shift_q;

   tcisp_fifo #(
      .WIDTH($bits(tcisp_pkg::tcisp_wr_s)),
      .DEPTH(tcisp_pkg::WR_FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(wr_word),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_head)
   );

   // outputs
   assign wr_addr = wr_head.addr;
   assign wr_data = wr_head.data;
   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign rd_req = rd_req_q;
   assign rd_addr = rd_addr_q;
   assign addr_alt = addr_alt_q;

endmodule

`default_nettype wire

// File: core/tcisp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser, output moves once stages two and three agree
module tcisp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level_q
);

   logic [W-1:0] s1_q; // first stage, read by s2 only
   logic [W-1:0] s2_q; // second stage
   logic [W-1:0] s3_q; // third stage

   // shift chain
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // per bit agreement filter
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (!nrst) begin
            level_q[i] <= RST[i];
         end else if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
         end
      end
   end

endmodule

`default_nettype wire

// File: testbench/tcisp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master, open drain, 80 ns bit period
module tcisp_host_model (
   input wire logic clk,
   output logic scl,
   output logic sda_h,
   input wire logic sda
);
   logic busy = 1'b0; // inside a frame
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   // one bit, data moves only while clock low; six low and two high, so a
   // slave drive change clears its pin filter before the clock rises
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      repeat (3) @(negedge clk);
      sda_h = b;
      repeat (3) @(negedge clk);
      scl = 1'b1;
      @(negedge clk);
      r = sda;
      @(negedge clk);
   endtask
   // start or repeated start
   task automatic start();
      if (busy) begin
         // wait out the slave's ack release before raising the clock
         scl = 1'b0;
         repeat (3) @(negedge clk);
         sda_h = 1'b1;
         repeat (3) @(negedge clk);
         scl = 1'b1;
      end
      repeat (4) @(negedge clk);
      sda_h = 1'b0;
      busy = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // stop, clock left high
   task automatic stop();
      scl = 1'b0;
      repeat (3) @(negedge clk);
      sda_h = 1'b0;
      repeat (3) @(negedge clk);
      scl = 1'b1;
      repeat (4) @(negedge clk);
      sda_h = 1'b1;
      busy = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // send a byte, msb first, return ack
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // take a byte, then ack or nack
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule
`default_nettype wire

// File: testbench/tcisp_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// pin and user side checks of the slave port
module tcisp_slave_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe,
   input wire logic addr_alt,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr
);
   logic scl_q, sda_q, idle_q, rs_q; // pin history, bus idle, fetch seen
   logic [3:0] cnt_q, ac_q; // scl rises since start, cycles since reset
   logic [7:0] sh_q; // first byte after start
   logic [15:0] la_q; // last fetch address
   logic st, sp; // raw start, raw stop
   logic [7:0] want; // selected write address
   assign st = scl_q & scl_i & sda_q & ~sda_i;
   assign sp = scl_q & scl_i & ~sda_q & sda_i;
   assign want = addr_alt ? tcisp_pkg::ADDR_PAIR1_WR : tcisp_pkg::ADDR_PAIR0_WR;
   // pin history
   always_ff @(posedge clk) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
   end
   // idle from stop to start
   always_ff @(posedge clk) begin
      if (!nrst || sp) begin
         idle_q <= 1'b1;
      end else if (st) begin
         idle_q <= 1'b0;
      end
   end
   // count scl rises, saturating
   always_ff @(posedge clk) begin
      if (!nrst || st) begin
         cnt_q <= 4'h0;
      end else if (scl_i && !scl_q && cnt_q != 4'hf) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // capture the address byte
   always_ff @(posedge clk) begin
      if (scl_i && !scl_q && cnt_q < 4'h8) begin
         sh_q <= {sh_q[6:0], sda_i};
      end
   end
   // cycles since reset, saturating
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ac_q <= 4'h0;
      end else if (ac_q != 4'hf) begin
         ac_q <= ac_q + 4'h1;
      end
   end
   // last fetch of this transfer
   always_ff @(posedge clk) begin
      if (!nrst || st) begin
         rs_q <= 1'b0;
      end else if (rd_req) begin
         rs_q <= 1'b1;
         la_q <= rd_addr;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_reset_clear: assert property ($rose(nrst) |-> !sda_oe && !rd_req && !wr_valid && !addr_alt)
      else $error("outputs not cleared by reset");
   a_idle_quiet: assert property (idle_q |-> !sda_oe)
      else $error("data driven while bus idle");
   a_ack_match: assert property ($fell(scl_i) && cnt_q == 4'h9 |-> sda_oe == (sh_q[7:1] == want[7:1]))
      else $error("address ack wrong");
   a_oe_late_change: assert property ($fell(scl_i) |=> $stable(sda_oe) [*2])
      else $error("data changed before clock low");
   a_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:100] !sda_oe)
      else $error("data held too long");
   a_rdreq_pulse: assert property (rd_req |=> !rd_req)
      else $error("fetch request too long");
   a_rd_step: assert property (rd_req && rs_q |-> rd_addr == la_q + 16'h0001)
      else $error("fetch address did not step");
   a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
      else $error("stalled write changed");
   a_alt_fixed: assert property (ac_q == 4'hf |-> $stable(addr_alt))
      else $error("address select moved");
   c_fetch: cover property (rd_req && rs_q);
   c_pop: cover property (wr_valid && wr_ready);
   c_miss: cover property ($fell(scl_i) && cnt_q == 4'h9 && !sda_oe);
endmodule
`default_nettype wire

// File: testbench/test_touch_ctrl_i2c_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module test_touch_ctrl_i2c_slave_port;
   logic clk = 1'b0, nrst = 1'b0, strap = 1'b0, hold = 1'b0; // bench drives
   logic wr_ready = 1'b1, rd_valid = 1'b0; // user side
   logic [7:0] rd_data = 8'h00, d; // fetch answer, read byte
   logic scl, sda_h, sda, sda_o, sda_oe, addr_alt, wr_valid, rd_req, a; // pins, flags
   logic [15:0] wr_addr, rd_addr; // addresses
   logic [7:0] wr_data; // write data
   logic [23:0] w; // popped word
   logic [23:0] wq[$]; // writes taken
   int n_fail = 0, compares = 0; // tallies
   assign sda = sda_h & (sda_oe ? sda_o : 1'b1); // pull-up wire
   initial begin
      forever #5 clk = ~clk;
   end
   tcisp_slave tcisp_slave_i (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_alt_strap(strap), .addr_alt(addr_alt), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   tcisp_host_model host_i (.clk(clk), .scl(scl), .sda_h(sda_h), .sda(sda));
   // register contents seen by reads
   function automatic logic [7:0] mem(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'h5a;
   endfunction
   // user side: take writes, answer fetches; the head is logged when the
   // ready set below lets the next rising edge pop it
   always @(negedge clk) begin
      if (wr_valid === 1'b1 && !hold) begin
         wq.push_back({wr_addr, wr_data});
      end
      wr_ready <= !hold;
      rd_valid <= rd_req;
      rd_data <= mem(rd_addr);
   end
   task automatic reset_dut(input logic alt);
      strap = alt;
      nrst = 1'b0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (10) @(negedge clk);
   endtask
   // start, address, pointer
   task automatic addr_ptr(input logic [7:0] ad, input logic [15:0] p);
      host_i.start();
      host_i.wbyte(ad, a); `CHK(a, 1'b1)
      host_i.wbyte(p[15:8], a); `CHK(a, 1'b1)
      host_i.wbyte(p[7:0], a); `CHK(a, 1'b1)
   endtask
   task automatic t_write;
      addr_ptr(8'hba, 16'h1234);
      for (int i = 0; i < 3; i++) begin
         host_i.wbyte(8'(8'h56 + i), a); `CHK(a, 1'b1)
      end
      host_i.stop();
      `CHK(wq.size(), 3)
      for (int i = 0; i < 3; i++) begin
         w = wq.pop_front(); `CHK(w, {16'(16'h1234 + i), 8'(8'h56 + i)})
      end
   endtask
   task automatic t_read;
      addr_ptr(8'hba, 16'h00ff);
      host_i.start();
      host_i.wbyte(8'hbb, a); `CHK(a, 1'b1)
      for (int i = 0; i < 3; i++) begin
         host_i.rbyte(i < 2, d); `CHK(d, mem(16'(16'h00ff + i)))
      end
      host_i.stop();
      `CHK(sda_oe, 1'b0)
   endtask
   task automatic t_miss;
      host_i.start();
      host_i.wbyte(8'h28, a); `CHK(a, 1'b0)
      host_i.wbyte(8'hba, a); `CHK(a, 1'b0)
      host_i.stop();
   endtask
   task automatic t_full;
      hold = 1'b1;
      addr_ptr(8'hba, 16'h0010);
      for (int i = 0; i < 9; i++) begin
         host_i.wbyte(8'(i), a); `CHK(a, 1'(i < 8))
      end
      host_i.stop();
      hold = 1'b0;
      for (int k = 0; k < 50 && wr_valid !== 1'b0; k++) @(negedge clk);
      `CHK(wq.size(), 8)
      for (int i = 0; i < 8; i++) begin
         w = wq.pop_front(); `CHK(w, {16'(16'h0010 + i), 8'(i)})
      end
   endtask
   task automatic t_alt;
      reset_dut(1'b1);
      `CHK(addr_alt, 1'b1)
      host_i.start();
      host_i.wbyte(8'hba, a); `CHK(a, 1'b0)
      host_i.stop();
      addr_ptr(8'h28, 16'h0005);
      host_i.start();
      host_i.wbyte(8'h29, a); `CHK(a, 1'b1)
      host_i.rbyte(1'b0, d); `CHK(d, mem(16'h0005))
      host_i.stop();
   endtask
   task automatic close_out;
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      reset_dut(1'b0);
      `CHK(addr_alt, 1'b0)
      t_write;
      t_read;
      t_miss;
      t_full;
      t_alt;
      close_out;
   end
   // watchdog, about eight times the expected run
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out;
   end
endmodule
bind tcisp_slave tcisp_slave_asserts tcisp_slave_asserts_i (.clk(clk), .nrst(nrst), .scl_i(scl_i),
   .sda_i(sda_i), .sda_oe(sda_oe), .addr_alt(addr_alt), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr));
`default_nettype wire
